/* File: hw/ecr_chan_decode.sv */
// per-channel routing, current scale and ambient input decode plus frame rate guard
`timescale 1ns/100ps
`include "ecr_map.svh"

module ecr_chan_decode #(
  parameter int MIN_CYC_NO_HDR   = 5000,
  parameter int MIN_CYC_AUTO_HDR = 10000
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire ecr_pkg::ecr_cfg_type cfg,
  input  wire logic [1:0]           active_channel,
  input  wire logic                 hdr_level,
  input  wire logic                 subframe_tick,
  input  wire logic [6:0]           subframe_count,
  input  wire logic                 auto_hdr_en,
  output logic [2:0]                drive_en,
  output logic [2:0]                current_scale,
  output logic [5:0]                ch2_current_dma,
  output logic                      scale_invalid,
  output logic [1:0]                ambient_select,
  output logic [9:0]                knee3,
  output logic                      frame_done,
  output logic                      rate_overrun
);

  ecr_pkg::ecr_dec_state_type q_r;
  ecr_pkg::ecr_dec_state_type q_nxt;
  logic [2:0]  scale_code;
  logic [15:0] min_cyc;

  // next-state: decode the selected channel and track frame spacing
  always_comb begin
    q_nxt = q_r;
    q_nxt.frame_done = 1'b0;
    scale_code = hdr_level ? cfg.ch2_high_current_scale : cfg.ch2_low_current_scale;
    min_cyc = auto_hdr_en ? 16'(MIN_CYC_AUTO_HDR) : 16'(MIN_CYC_NO_HDR);
    q_nxt.current_scale = 3'h0;
    q_nxt.ch2_current_dma = 6'h00;
    q_nxt.scale_invalid = 1'b0;
    unique case (active_channel)
      2'd0: begin
        q_nxt.drive_en = 3'b001;
        q_nxt.ambient_select = cfg.ch0_ambient_input_select;
      end
      2'd1: begin
        q_nxt.drive_en = cfg.route_ch1_to_ch0 ? 3'b001 : 3'b010;
        q_nxt.ambient_select = cfg.ch1_ambient_input_select;
      end
      2'd2: begin
        q_nxt.drive_en = cfg.route_ch2_to_ch0 ? 3'b001 : 3'b100;
        q_nxt.ambient_select = cfg.ch2_ambient_input_select;
        q_nxt.current_scale = scale_code;
        q_nxt.scale_invalid = scale_code[2];
        if (!scale_code[2]) begin
          // 5.6 mA minus 1.4 mA per code step, in tenths of a mA
          q_nxt.ch2_current_dma = `ECR_SCALE_TOP_DMA - 6'(`ECR_SCALE_STEP_DMA * scale_code[1:0]);
        end
      end
      default: begin
        q_nxt.drive_en = 3'b000; // no channel active
        q_nxt.ambient_select = 2'h0;
      end
    endcase
    q_nxt.knee3 = cfg.ambient_correction_knee3;
    if (q_r.period_cnt != 16'hFFFF) begin
      q_nxt.period_cnt = q_r.period_cnt + 16'h0001;
    end
    if (subframe_tick) begin
      if (q_r.sf_cnt == subframe_count) begin
        q_nxt.sf_cnt = 7'h00;
        q_nxt.frame_done = 1'b1;
        q_nxt.rate_overrun = (q_r.period_cnt < min_cyc);
        q_nxt.period_cnt = 16'h0000;
      end else begin
        q_nxt.sf_cnt = q_r.sf_cnt + 7'h01;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q_r <= '0;
      q_r.knee3 <= 10'(`ECR_ROUTE_SCALE_RST & 24'h0003FF);
    end else begin
      q_r <= q_nxt;
    end
  end

  assign drive_en        = q_r.drive_en;
  assign current_scale   = q_r.current_scale;
  assign ch2_current_dma = q_r.ch2_current_dma;
  assign scale_invalid   = q_r.scale_invalid;
  assign ambient_select  = q_r.ambient_select;
  assign knee3           = q_r.knee3;
  assign frame_done      = q_r.frame_done;
  assign rate_overrun    = q_r.rate_overrun;

endmodule

/* File: hw/ecr_map.svh */
// register offset, field reset values and timing counts for the emitter config block
`ifndef ECR_MAP_SVH
`define ECR_MAP_SVH

`define ECR_REG_ROUTE_SCALE   8'hB9
`define ECR_ROUTE_SCALE_RST   24'h0001FF
`define ECR_I2C_DEV_ADDR      7'h58
`define ECR_CLK_HZ            20000000
`define ECR_MAX_SPS_NO_HDR    4000
`define ECR_MAX_SPS_AUTO_HDR  2000
`define ECR_MIN_CYC_NO_HDR    ((`ECR_CLK_HZ + `ECR_MAX_SPS_NO_HDR - 1) / `ECR_MAX_SPS_NO_HDR)
`define ECR_MIN_CYC_AUTO_HDR  ((`ECR_CLK_HZ + `ECR_MAX_SPS_AUTO_HDR - 1) / `ECR_MAX_SPS_AUTO_HDR)
`define ECR_SCALE_TOP_DMA     6'h38
`define ECR_SCALE_STEP_DMA    6'h0E

`endif

/* File: hw/ecr_pkg.sv */
// types shared by the emitter config register and its channel decoder
package ecr_pkg;

  // field order matches the register bit layout, msb first
  typedef struct packed {
    logic [2:0] ch2_high_current_scale;
    logic [2:0] ch2_low_current_scale;
    logic [1:0] ch2_ambient_input_select;
    logic [1:0] ch1_ambient_input_select;
    logic [1:0] ch0_ambient_input_select;
    logic       route_ch2_to_ch0;
    logic       route_ch1_to_ch0;
    logic [9:0] ambient_correction_knee3;
  } ecr_cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_RX, ST_ACK_RX, ST_TX, ST_ACK_TX
  } ecr_i2c_state_type;

  typedef struct packed {
    logic [2:0] drive_en;
    logic [2:0] current_scale;
    logic [5:0] ch2_current_dma;
    logic       scale_invalid;
    logic [1:0] ambient_select;
    logic [9:0] knee3;
    logic [6:0] sf_cnt;
    logic [15:0] period_cnt;
    logic       frame_done;
    logic       rate_overrun;
  } ecr_dec_state_type;

  typedef struct packed {
    logic [1:0]        scl_sync;
    logic              scl_d;
    logic [1:0]        sda_sync;
    logic              sda_d;
    ecr_i2c_state_type state;
    logic [2:0]        bitcnt;
    logic              full;
    logic [7:0]        shreg;
    logic [7:0]        txreg;
    logic              rw;
    logic              nack;
    logic [7:0]        reg_ptr;
    logic [1:0]        byte_idx;
    logic [15:0]       wr_buf;
    ecr_cfg_type       cfg;
    logic              sda_out;
    logic              sda_oe_n;
  } ecr_top_state_type;

endpackage

/* File: hw/ecr_top.sv */
// emitter channel config register with its two-wire serial slave
`timescale 1ns/100ps
`include "ecr_map.svh"

// Operation
// - The 3-bit high-level channel 2 scale maps 0..3 to 5.6, 4.2, 2.8, 1.4 mA; 4..7 are invalid.
// - The 3-bit low-level channel 2 scale uses the same mapping; other codes are invalid.
// - With channel 2 active, bits 17:16 choose the ambient converter input pair.
// - With channel 1 active, bits 15:14 choose the ambient converter input pair.
// - With channel 0 active, bits 13:12 choose the ambient converter input pair.
// - Bit 11 set sends channel 2 drive out through the channel 0 output.
// - Bit 10 set sends channel 1 drive out through the channel 0 output.
// - Bits 9:0 hold the third ambient correction knee, reset 1FFh, all else resets to zero.
// - A frame completes after the programmed number of sub-frames plus one.
// - Frames are checked against 4000 sps without auto HDR and 2000 sps with it.
module ecr_top #(
  parameter logic [6:0] DEV_ADDR         = `ECR_I2C_DEV_ADDR, // arbitrary bus address
  parameter int         MIN_CYC_NO_HDR   = `ECR_MIN_CYC_NO_HDR,
  parameter int         MIN_CYC_AUTO_HDR = `ECR_MIN_CYC_AUTO_HDR
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic [1:0] active_channel,
  input  wire logic       hdr_level,
  input  wire logic       subframe_tick,
  input  wire logic [6:0] subframe_count,
  input  wire logic       auto_hdr_en,
  output logic [2:0]      drive_en,
  output logic [2:0]      current_scale,
  output logic [5:0]      ch2_current_dma,
  output logic            scale_invalid,
  output logic [1:0]      ambient_select,
  output logic [9:0]      knee3,
  output logic            frame_done,
  output logic            rate_overrun,
  output logic [23:0]     cfg_word
);

  ecr_pkg::ecr_top_state_type q_r;
  ecr_pkg::ecr_top_state_type q_nxt;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic [23:0] rd_word;
  logic [7:0]  rd_byte;

  // bus edge and condition detect, only on the second sync stage
  assign scl_rise   = q_r.scl_sync[1] & ~q_r.scl_d;
  assign scl_fall   = ~q_r.scl_sync[1] & q_r.scl_d;
  assign start_seen = q_r.scl_sync[1] & q_r.scl_d & q_r.sda_d & ~q_r.sda_sync[1];
  assign stop_seen  = q_r.scl_sync[1] & q_r.scl_d & ~q_r.sda_d & q_r.sda_sync[1];

  // read data: the mapped register or zero for any other offset
  assign rd_word = (q_r.reg_ptr == `ECR_REG_ROUTE_SCALE) ? q_r.cfg : 24'h000000;
  always_comb begin
    unique case (q_r.byte_idx)
      2'd0:    rd_byte = rd_word[23:16];
      2'd1:    rd_byte = rd_word[15:8];
      2'd2:    rd_byte = rd_word[7:0];
      default: rd_byte = 8'h00; // past the last byte
    endcase
  end

  // next-state: serial slave protocol and register update
  always_comb begin
    q_nxt = q_r;
    q_nxt.scl_sync = {q_r.scl_sync[0], scl_in};
    q_nxt.sda_sync = {q_r.sda_sync[0], sda_in};
    q_nxt.scl_d = q_r.scl_sync[1];
    q_nxt.sda_d = q_r.sda_sync[1];
    q_nxt.sda_out = 1'b0; // open drain: only ever pulls low
    if (start_seen) begin
      q_nxt.state = ecr_pkg::ST_ADDR;
      q_nxt.bitcnt = 3'h0;
      q_nxt.full = 1'b0;
      q_nxt.byte_idx = 2'h0;
      q_nxt.sda_oe_n = 1'b1;
    end else if (stop_seen) begin
      q_nxt.state = ecr_pkg::ST_IDLE;
      q_nxt.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      unique case (q_r.state)
        ecr_pkg::ST_ADDR, ecr_pkg::ST_RX: begin
          q_nxt.shreg = {q_r.shreg[6:0], q_r.sda_sync[1]};
          q_nxt.bitcnt = q_r.bitcnt + 3'h1;
          if (q_r.bitcnt == 3'h7) begin
            q_nxt.full = 1'b1;
          end
        end
        ecr_pkg::ST_ACK_TX: q_nxt.nack = q_r.sda_sync[1];
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (q_r.state)
        ecr_pkg::ST_ADDR: begin
          if (q_r.full) begin
            q_nxt.full = 1'b0;
            if (q_r.shreg[7:1] == DEV_ADDR) begin
              q_nxt.rw = q_r.shreg[0];
              q_nxt.sda_oe_n = 1'b0; // acknowledge
              q_nxt.state = ecr_pkg::ST_ACK_ADDR;
            end else begin
              q_nxt.state = ecr_pkg::ST_IDLE;
            end
          end
        end
        ecr_pkg::ST_RX: begin
          if (q_r.full) begin
            q_nxt.full = 1'b0;
            q_nxt.sda_oe_n = 1'b0;
            q_nxt.state = ecr_pkg::ST_ACK_RX;
            if (q_r.byte_idx != 2'h3) begin
              q_nxt.byte_idx = q_r.byte_idx + 2'h1;
            end
            unique case (q_r.byte_idx)
              2'd0: q_nxt.reg_ptr = q_r.shreg;
              2'd1: q_nxt.wr_buf[15:8] = q_r.shreg;
              2'd2: q_nxt.wr_buf[7:0] = q_r.shreg;
              default: begin
                // whole word lands at once on the last byte
                if (q_r.reg_ptr == `ECR_REG_ROUTE_SCALE) begin
                  q_nxt.cfg = {q_r.wr_buf, q_r.shreg};
                end
              end
            endcase
          end
        end
        ecr_pkg::ST_ACK_ADDR: begin
          q_nxt.bitcnt = 3'h0;
          if (q_r.rw) begin
            q_nxt.sda_oe_n = rd_byte[7];
            q_nxt.txreg = {rd_byte[6:0], 1'b0};
            q_nxt.state = ecr_pkg::ST_TX;
          end else begin
            q_nxt.sda_oe_n = 1'b1;
            q_nxt.state = ecr_pkg::ST_RX;
          end
        end
        ecr_pkg::ST_ACK_RX: begin
          q_nxt.sda_oe_n = 1'b1;
          q_nxt.bitcnt = 3'h0;
          q_nxt.state = ecr_pkg::ST_RX;
        end
        ecr_pkg::ST_TX: begin
          q_nxt.bitcnt = q_r.bitcnt + 3'h1;
          if (q_r.bitcnt == 3'h7) begin
            q_nxt.sda_oe_n = 1'b1; // release for host ack
            q_nxt.state = ecr_pkg::ST_ACK_TX;
            if (q_r.byte_idx != 2'h3) begin
              q_nxt.byte_idx = q_r.byte_idx + 2'h1;
            end
          end else begin
            q_nxt.sda_oe_n = q_r.txreg[7];
            q_nxt.txreg = {q_r.txreg[6:0], 1'b0};
          end
        end
        ecr_pkg::ST_ACK_TX: begin
          q_nxt.bitcnt = 3'h0;
          if (q_r.nack) begin
            q_nxt.state = ecr_pkg::ST_IDLE;
          end else begin
            q_nxt.sda_oe_n = rd_byte[7];
            q_nxt.txreg = {rd_byte[6:0], 1'b0};
            q_nxt.state = ecr_pkg::ST_TX;
          end
        end
        default: ;
      endcase
    end
  end

  // state register; knee resets to 1FFh, bus sync stages, scl_d, sda_d and sda_oe_n to one, every other field to zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q_r <= '0;
      q_r.scl_sync <= 2'b11;
      q_r.scl_d <= 1'b1;
      q_r.sda_sync <= 2'b11;
      q_r.sda_d <= 1'b1;
      q_r.state <= ecr_pkg::ST_IDLE;
      q_r.cfg <= `ECR_ROUTE_SCALE_RST;
      q_r.sda_oe_n <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sda_out  = q_r.sda_out;
  assign sda_oe_n = q_r.sda_oe_n;
  assign cfg_word = q_r.cfg;

  // channel decode and frame rate guard
  ecr_chan_decode #(
    .MIN_CYC_NO_HDR   (MIN_CYC_NO_HDR),
    .MIN_CYC_AUTO_HDR (MIN_CYC_AUTO_HDR)
  ) u_dec (
    .sys_clk         (sys_clk),
    .srst            (srst),
    .cfg             (q_r.cfg),
    .active_channel  (active_channel),
    .hdr_level       (hdr_level),
    .subframe_tick   (subframe_tick),
    .subframe_count  (subframe_count),
    .auto_hdr_en     (auto_hdr_en),
    .drive_en        (drive_en),
    .current_scale   (current_scale),
    .ch2_current_dma (ch2_current_dma),
    .scale_invalid   (scale_invalid),
    .ambient_select  (ambient_select),
    .knee3           (knee3),
    .frame_done      (frame_done),
    .rate_overrun    (rate_overrun)
  );

endmodule

/* File: tb/ecr_i2c_host.sv */
// two-wire bus host model that reaches the emitter config register
`timescale 1ns/100ps
module ecr_i2c_host #(
  parameter logic [6:0] ADDR = 7'h58 // arbitrary bus address
) (
  input  wire logic   sys_clk,
  input  wire logic   sda_in,
  output logic        scl,
  output logic        sda_low,
  output logic        rd_valid,
  output logic [23:0] rd_data
);
  localparam int H = 5;
  // bus idles released, clock high and still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_valid = 1'b0;
    rd_data = 24'h000000;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // data changes only while the clock is low
  task automatic xb(input logic b, output logic r);
    tk(1);
    sda_low <= !b;
    tk(H);
    scl <= 1'b1;
    tk(H);
    r = sda_in;
    scl <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ak, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) xb(d[i], r[i]);
    xb(ak, a);
  endtask
  task automatic start;
    tk(1);
    sda_low <= 1'b0;
    tk(H);
    scl <= 1'b1;
    tk(H);
    sda_low <= 1'b1;
    tk(H);
    scl <= 1'b0;
  endtask
  task automatic stop;
    tk(1);
    sda_low <= 1'b1;
    tk(H);
    scl <= 1'b1;
    tk(H);
    sda_low <= 1'b0;
    tk(H);
  endtask
  task automatic write(input logic [7:0] o, input logic [23:0] d);
    logic [7:0] r;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, r);
    xbyte(o, 1'b1, r);
    for (int k = 2; k >= 0; k--) xbyte(d[8*k +: 8], 1'b1, r);
    stop();
  endtask
  // offset first, then repeated start; host nacks the last byte
  task automatic read(input logic [7:0] o);
    logic [7:0]  r;
    logic [23:0] v;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, r);
    xbyte(o, 1'b1, r);
    start();
    xbyte({ADDR, 1'b1}, 1'b1, r);
    for (int k = 2; k >= 0; k--) xbyte(8'hFF, k == 0, v[8*k +: 8]);
    rd_data <= v;
    rd_valid <= 1'b1;
    tk(1);
    rd_valid <= 1'b0;
    stop();
  endtask
endmodule

/* File: tb/ecr_top_sva.sv */
// assertions on the emitter config block outputs
`timescale 1ns/100ps
module ecr_top_sva (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [1:0]  active_channel,
  input wire logic        hdr_level,
  input wire logic        subframe_tick,
  input wire logic [2:0]  drive_en,
  input wire logic [2:0]  current_scale,
  input wire logic [5:0]  ch2_current_dma,
  input wire logic        scale_invalid,
  input wire logic [1:0]  ambient_select,
  input wire logic [9:0]  knee3,
  input wire logic        frame_done,
  input wire logic        rate_overrun,
  input wire logic [23:0] cfg_word
);
  logic [23:0] cfg_prev_r;
  logic        cfg_held;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // previous register value, so checks skip the cycle a write lands
  always_ff @(posedge sys_clk) cfg_prev_r <= cfg_word;
  assign cfg_held = cfg_word == cfg_prev_r;
  property p_rst;
    disable iff (1'b0) srst ##1 srst |=> cfg_word == 24'h0001FF && knee3 == 10'h1FF;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_knee;
    cfg_held |-> knee3 == cfg_word[9:0];
  endproperty
  a_knee: assert property (p_knee) else $error("knee3 wrong");
  property p_ch0;
    active_channel == 2'h0 |=> !cfg_held ||
      drive_en == 3'h1 && ambient_select == cfg_prev_r[13:12];
  endproperty
  a_ch0: assert property (p_ch0) else $error("channel 0 decode wrong");
  property p_amb1;
    active_channel == 2'h1 |=> !cfg_held || ambient_select == cfg_prev_r[15:14];
  endproperty
  a_amb1: assert property (p_amb1) else $error("channel 1 ambient wrong");
  property p_rt1;
    active_channel == 2'h1 |=> !cfg_held || drive_en == (cfg_prev_r[10] ? 3'h1 : 3'h2);
  endproperty
  a_rt1: assert property (p_rt1) else $error("channel 1 routing wrong");
  property p_amb2;
    active_channel == 2'h2 |=> !cfg_held || ambient_select == cfg_prev_r[17:16];
  endproperty
  a_amb2: assert property (p_amb2) else $error("channel 2 ambient wrong");
  property p_rt2;
    active_channel == 2'h2 |=> !cfg_held || drive_en == (cfg_prev_r[11] ? 3'h1 : 3'h4);
  endproperty
  a_rt2: assert property (p_rt2) else $error("channel 2 routing wrong");
  property p_hi;
    active_channel == 2'h2 && hdr_level |=> !cfg_held || (cfg_prev_r[23:21] > 3'h3 ?
      scale_invalid : ch2_current_dma == 6'h38 - 6'h0E * cfg_prev_r[23:21]);
  endproperty
  a_hi: assert property (p_hi) else $error("high scale wrong");
  property p_lo;
    active_channel == 2'h2 && !hdr_level |=> !cfg_held || (cfg_prev_r[20:18] > 3'h3 ?
      scale_invalid : ch2_current_dma == 6'h38 - 6'h0E * cfg_prev_r[20:18]);
  endproperty
  a_lo: assert property (p_lo) else $error("low scale wrong");
  property p_scl;
    active_channel == 2'h2 |=> !cfg_held ||
      current_scale == ($past(hdr_level) ? cfg_prev_r[23:21] : cfg_prev_r[20:18]);
  endproperty
  a_scl: assert property (p_scl) else $error("scale code wrong");
  property p_scl_off;
    active_channel != 2'h2 |=> current_scale == 3'h0;
  endproperty
  a_scl_off: assert property (p_scl_off) else $error("scale code outside channel 2");
  property p_frame;
    frame_done |-> $past(subframe_tick);
  endproperty
  a_frame: assert property (p_frame) else $error("frame without tick");
  property p_ovr;
    !frame_done && !$past(frame_done) |-> $stable(rate_overrun);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun moved off frame");
endmodule

bind ecr_top ecr_top_sva u_sva (.sys_clk, .srst, .active_channel, .hdr_level, .subframe_tick,
  .drive_en, .current_scale, .ch2_current_dma, .scale_invalid, .ambient_select, .knee3,
  .frame_done, .rate_overrun, .cfg_word);

/* File: tb/ecr_top_tb.sv */
// self-checking bench for the emitter config block
`timescale 1ns/100ps
module ecr_top_tb;
  logic        sys_clk = 1'b0, srst = 1'b1, tick = 1'b0, hdr = 1'b0, ahdr = 1'b0;
  logic [1:0]  ch = 2'h3;
  logic [6:0]  sfc = 7'h03;
  logic        scl, sda_low, rd_valid, sda_oe_n, inv, fd, ovr;
  logic [23:0] rd_data, v;
  logic [2:0]  drive_en;
  logic [1:0]  amb;
  logic [5:0]  dma;
  logic [23:0] exp_q[$];
  int          n_fail = 0, checks_done = 0, fd_n = 0, cyc = 0;
  wire logic   sda_w = !(sda_low || !sda_oe_n);
  ecr_i2c_host u_host (.sys_clk, .sda_in(sda_w), .scl, .sda_low, .rd_valid, .rd_data);
  ecr_top #(.MIN_CYC_NO_HDR(20), .MIN_CYC_AUTO_HDR(60)) u_dut (.sys_clk, .srst, .scl_in(scl),
    .sda_in(sda_w), .sda_out(), .sda_oe_n, .active_channel(ch), .hdr_level(hdr),
    .subframe_tick(tick), .subframe_count(sfc), .auto_hdr_en(ahdr), .drive_en,
    .current_scale(), .ch2_current_dma(dma), .scale_invalid(inv), .ambient_select(amb),
    .knee3(), .frame_done(fd), .rate_overrun(ovr), .cfg_word());
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // drive en, ambient code, ch2 current and invalid flag for one setting
  function automatic logic [11:0] exp_dec(input logic [23:0] w, input logic [1:0] c,
                                          input logic h);
    logic [2:0] s;
    logic [1:0] a;
    s = h ? w[23:21] : w[20:18];
    a = w[12 + 2*c +: 2];
    case (c)
      2'h0: return {3'h1, a, 7'h00};
      2'h1: return {w[10] ? 3'h1 : 3'h2, a, 7'h00};
      2'h2: return {w[11] ? 3'h1 : 3'h4, a, s > 3'h3 ? 7'h01 : {6'h38 - 6'h0E * s, 1'b0}};
      default: return 12'h000;
    endcase
  endfunction
  task automatic dec(input logic [1:0] c, input logic h, input logic [11:0] e);
    @(posedge sys_clk);
    ch <= c;
    hdr <= h;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp({12'h000, drive_en, amb, dma, inv}, {12'h000, e});
  endtask
  task automatic rd(input logic [7:0] o, input logic [23:0] e);
    exp_q.push_back(e);
    u_host.read(o);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
  endtask
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // watchdog, frame counter and read-back comparison
  always @(posedge sys_clk) begin
    cyc++;
    if (fd === 1'b1) fd_n++;
    if (rd_valid) cmp(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data);
    if (cyc > 60000) begin
      n_fail++;
      summarize();
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'h147F));
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'hB9, 24'h0001FF);
    for (int i = 0; i < 8; i++) begin
      v = $urandom();
      v[23:18] = {i[2:0], 3'h7 - i[2:0]};
      v[17:10] = {i[1:0], ~i[1:0], i[2:1], i[0], i[1]};
      u_host.write(8'hB9, v);
      rd(8'hB9, v);
      for (int c = 0; c < 4; c++) begin
        dec(c[1:0], 1'b1, exp_dec(v, c[1:0], 1'b1));
        dec(c[1:0], 1'b0, exp_dec(v, c[1:0], 1'b0));
      end
    end
    u_host.write(8'hB8, ~v);
    rd(8'hB9, v);
    rd(8'hB8, 24'h000000);
    fd_n = 0;
    frames(8);
    @(negedge sys_clk);
    cmp({fd_n[22:0], ovr}, {23'h2, 1'b0});
    @(posedge sys_clk);
    ahdr <= 1'b1;
    fd_n = 0;
    frames(8);
    @(negedge sys_clk);
    cmp({fd_n[22:0], ovr}, {23'h2, 1'b1});
    summarize();
  end
endmodule
